// *** core/fip_defines.vh ***
// constants for the format init pattern filler
`ifndef FIP_DEFINES_VH
`define FIP_DEFINES_VH
// ----------------------------------------
// descriptor layout
// ----------------------------------------
`define FIP_HDR_BYTES 3'h4
`define FIP_SEL_MSB 7
`define FIP_SEL_LSB 6
// ----------------------------------------
// selector and type codes
// ----------------------------------------
`define FIP_SEL_NONE 2'h0
`define FIP_SEL_LOGICAL 2'h1
`define FIP_SEL_PHYSICAL 2'h2
`define FIP_SEL_RSVD 2'h3
`define FIP_TYPE_DEFAULT 8'h00
`define FIP_TYPE_REPEAT 8'h01
// ----------------------------------------
// fill settings
// ----------------------------------------
`define FIP_DEFAULT_FILL 8'h00
`define FIP_PAT_MAX 16'h0010
`define FIP_PAT_AW 4
`define FIP_ADDR_BYTES 16'h0004
`define FIP_FIFO_DEPTH 4
`define FIP_FIFO_WIDTH 9
`endif

// *** core/fip_fifo.v ***
// small synchronous fifo for the fill byte stream
`timescale 1ns/10ps
`default_nettype none
module fip_fifo #(
	parameter WIDTH = 9,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// fill side
	input wire [WIDTH-1:0] in_data_in,
	input wire in_valid_in,
	output wire in_ready_out,
	// drain side
	output wire [WIDTH-1:0] out_data_out,
	output wire out_valid_out,
	input wire out_ready_in
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;
	integer i;

	assign in_ready_out = (count_q != DEPTH[AW:0]);
	assign out_valid_out = (count_q != {(AW+1){1'b0}});
	assign out_data_out = mem_q[rd_ptr_q];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data_in;
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // fip_fifo
`default_nettype wire

// *** core/fip_filler.v ***
// format init pattern descriptor decoder and block filler
//
// Behaviour
// - Descriptor byte 0 bits 7:6 hold the selector, byte 1 the type, bytes 2-3 the length MSB first, pattern from byte 4.
// - Selector 00b writes the pattern unchanged and selector 11b is reserved.
// - Selector 01b puts the logical block address, MSB first, in the first four bytes of each logical block.
// - Selector 10b puts, MSB first, the lowest logical block address found in each physical block into its first four bytes.
// - Type 00h picks the default fill, 02h-7Fh are reserved and 80h-FFh are vendor-defined.
// - Type 01h repeats the supplied pattern bytes cyclically until each logical block is full.
// - Default type with a nonzero length ends the command with illegal request, invalid parameter field.
// - Repeat type with a zero length ends the command with illegal request, invalid parameter field.
// - A length above the logical block size ends the command with illegal request, invalid parameter field.
// - Every byte of every logical block is written from the pattern, with any address overlay taking precedence over it.
// - Only the initiator-accessible blocks, counted by block_count_in, are written.
// - The descriptor exists only with the pattern-present flag set and follows the defect list header, else default fill.
// - The defect list length excludes the descriptor, so that many bytes are skipped before it.
`timescale 1ns/10ps
`default_nettype none
`include "fip_defines.vh"
module fip_filler #(
	parameter [3:0] SENSE_ILLEGAL_REQUEST = 4'h5,
	parameter [7:0] ASC_INVALID_PARAM_FIELD = 8'h26
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// command setup
	input wire start_in,
	input wire pattern_present_flag_in,
	input wire [15:0] defect_len_in,
	input wire [15:0] block_size_in,
	input wire [15:0] phys_size_in,
	input wire [31:0] block_count_in,
	// parameter list bytes after the defect list header
	input wire [7:0] param_data_in,
	input wire param_valid_in,
	output wire param_ready_out,
	// fill byte stream to the medium
	output wire [7:0] wr_data_out,
	output wire wr_last_out,
	output wire wr_valid_out,
	input wire wr_ready_in,
	// status
	output wire busy_out,
	output wire done_out,
	output wire check_cond_out,
	output wire [3:0] sense_key_out,
	output wire [7:0] asc_out
);
	// ----------------------------------------
	// state encoding
	// ----------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SKIP = 3'h1;
	localparam [2:0] ST_HDR = 3'h2;
	localparam [2:0] ST_CHECK = 3'h3;
	localparam [2:0] ST_PAT = 3'h4;
	localparam [2:0] ST_FILL = 3'h5;

	// address byte, most significant first
	function [7:0] addr_byte;
		input [31:0] addr;
		input [1:0] idx;
		begin
			case (idx)
				2'h0: addr_byte = addr[31:24];
				2'h1: addr_byte = addr[23:16];
				2'h2: addr_byte = addr[15:8];
				default: addr_byte = addr[7:0];
			endcase
		end
	endfunction

	reg [2:0] state_q;
	reg [15:0] skip_q;
	reg [1:0] hidx_q;
	reg [1:0] sel_q;
	reg [7:0] type_q;
	reg [15:0] len_q;
	reg [7:0] pat_q [0:`FIP_PAT_MAX-1];
	reg [15:0] pidx_q;
	reg [15:0] bcnt_q;
	reg [15:0] pcnt_q;
	reg [31:0] lba_q;
	reg [31:0] phys_lba_q;
	reg done_q;
	reg check_q;
	reg [15:0] bsize_q;
	reg [15:0] psize_q;
	reg [31:0] bcount_q;
	reg [7:0] fill_byte;
	wire take;
	wire push;
	wire fifo_ready;
	wire blk_end;
	wire [31:0] cur_phys_lba;
	wire reject;
	integer i;

	assign param_ready_out = (state_q == ST_SKIP) || (state_q == ST_HDR) || (state_q == ST_PAT);
	assign take = param_ready_out && param_valid_in;
	assign push = (state_q == ST_FILL) && fifo_ready;
	assign blk_end = (bcnt_q == bsize_q - 16'h0001);
	assign busy_out = (state_q != ST_IDLE);
	assign done_out = done_q;
	assign check_cond_out = check_q;
	assign sense_key_out = check_q ? SENSE_ILLEGAL_REQUEST : 4'h0;
	assign asc_out = check_q ? ASC_INVALID_PARAM_FIELD : 8'h00;

	// a physical block opening here starts with the current logical block
	assign cur_phys_lba = (pcnt_q == 16'h0000) ? lba_q : phys_lba_q;

	// ----------------------------------------
	// descriptor checks
	// ----------------------------------------
	// vendor types carry no local meaning here, so they are refused too
	assign reject = (sel_q == `FIP_SEL_RSVD) ||
		((type_q != `FIP_TYPE_DEFAULT) && (type_q != `FIP_TYPE_REPEAT)) ||
		((type_q == `FIP_TYPE_DEFAULT) && (len_q != 16'h0000)) ||
		((type_q == `FIP_TYPE_REPEAT) && (len_q == 16'h0000)) ||
		(len_q > bsize_q) ||
		(len_q > `FIP_PAT_MAX); // pattern store is small

	// ----------------------------------------
	// fill byte
	// ----------------------------------------
	always @* begin
		if (type_q == `FIP_TYPE_REPEAT) begin
			fill_byte = pat_q[pidx_q[`FIP_PAT_AW-1:0]];
		end else begin
			fill_byte = `FIP_DEFAULT_FILL;
		end
		// overlay goes on top of the pattern, never instead of the count
		if ((sel_q == `FIP_SEL_LOGICAL) && (bcnt_q < `FIP_ADDR_BYTES)) begin
			fill_byte = addr_byte(lba_q, bcnt_q[1:0]);
		end else if ((sel_q == `FIP_SEL_PHYSICAL) && (pcnt_q < `FIP_ADDR_BYTES)) begin
			fill_byte = addr_byte(cur_phys_lba, pcnt_q[1:0]);
		end
	end

	// ----------------------------------------
	// control
	// ----------------------------------------
	always @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			skip_q <= 16'h0000;
			hidx_q <= 2'h0;
			sel_q <= `FIP_SEL_NONE;
			type_q <= `FIP_TYPE_DEFAULT;
			len_q <= 16'h0000;
			pidx_q <= 16'h0000;
			bcnt_q <= 16'h0000;
			pcnt_q <= 16'h0000;
			lba_q <= 32'h00000000;
			phys_lba_q <= 32'h00000000;
			done_q <= 1'b0;
			check_q <= 1'b0;
			bsize_q <= 16'h0000;
			psize_q <= 16'h0000;
			bcount_q <= 32'h00000000;
			for (i = 0; i < `FIP_PAT_MAX; i = i + 1) begin
				pat_q[i] <= 8'h00;
			end
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (start_in) begin
						check_q <= 1'b0;
						skip_q <= defect_len_in;
						bsize_q <= block_size_in;
						psize_q <= phys_size_in;
						bcount_q <= block_count_in;
						sel_q <= `FIP_SEL_NONE;
						type_q <= `FIP_TYPE_DEFAULT;
						len_q <= 16'h0000;
						hidx_q <= 2'h0;
						pidx_q <= 16'h0000;
						bcnt_q <= 16'h0000;
						pcnt_q <= 16'h0000;
						lba_q <= 32'h00000000;
						state_q <= ST_SKIP;
					end
				end
				ST_SKIP: begin
					if (skip_q == 16'h0000) begin
						state_q <= pattern_present_flag_in ? ST_HDR : ST_CHECK;
					end else if (take) begin
						skip_q <= skip_q - 16'h0001;
					end
				end
				ST_HDR: begin
					if (take) begin
						hidx_q <= hidx_q + 2'h1;
						case (hidx_q)
							2'h0: sel_q <= param_data_in[`FIP_SEL_MSB:`FIP_SEL_LSB];
							2'h1: type_q <= param_data_in;
							2'h2: len_q[15:8] <= param_data_in;
							default: begin
								len_q[7:0] <= param_data_in;
								state_q <= ST_CHECK;
							end
						endcase
					end
				end
				ST_CHECK: begin
					if (reject) begin
						check_q <= 1'b1;
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end else if (len_q != 16'h0000) begin
						state_q <= ST_PAT;
					end else if (bcount_q == 32'h00000000) begin
						done_q <= 1'b1;
						state_q <= ST_IDLE;
					end else begin
						state_q <= ST_FILL;
					end
				end
				ST_PAT: begin
					if (take) begin
						pat_q[pidx_q[`FIP_PAT_AW-1:0]] <= param_data_in;
						if (pidx_q == len_q - 16'h0001) begin
							pidx_q <= 16'h0000;
							if (bcount_q == 32'h00000000) begin
								done_q <= 1'b1;
								state_q <= ST_IDLE;
							end else begin
								state_q <= ST_FILL;
							end
						end else begin
							pidx_q <= pidx_q + 16'h0001;
						end
					end
				end
				ST_FILL: begin
					if (push) begin
						if (pcnt_q == 16'h0000) begin
							phys_lba_q <= lba_q;
						end
						pcnt_q <= (pcnt_q == psize_q - 16'h0001) ? 16'h0000 : pcnt_q + 16'h0001;
						if (blk_end) begin
							bcnt_q <= 16'h0000;
							pidx_q <= 16'h0000;
							lba_q <= lba_q + 32'h00000001;
							if (lba_q + 32'h00000001 == bcount_q) begin
								done_q <= 1'b1;
								state_q <= ST_IDLE;
							end
						end else begin
							bcnt_q <= bcnt_q + 16'h0001;
							pidx_q <= (pidx_q == len_q - 16'h0001) ? 16'h0000 : pidx_q + 16'h0001;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// output buffering
	// ----------------------------------------
	// the fifo absorbs short medium stalls; a full fifo stalls the fill counters
	fip_fifo #(
		.WIDTH(`FIP_FIFO_WIDTH),
		.DEPTH(`FIP_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_data_in({blk_end, fill_byte}),
		.in_valid_in(state_q == ST_FILL),
		.in_ready_out(fifo_ready),
		.out_data_out({wr_last_out, wr_data_out}),
		.out_valid_out(wr_valid_out),
		.out_ready_in(wr_ready_in)
	);
endmodule // fip_filler
`default_nettype wire

// *** tb/fip_filler_props.sv ***
// port assertions for the pattern filler
`timescale 1ns/10ps
`default_nettype none
module fip_filler_props #(
	parameter [3:0] SENSE_ILLEGAL_REQUEST = 4'h5,
	parameter [7:0] ASC_INVALID_PARAM_FIELD = 8'h26
) (
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// command side
	input wire start_in,
	input wire param_ready_out,
	// fill stream
	input wire [7:0] wr_data_out,
	input wire wr_last_out,
	input wire wr_valid_out,
	input wire wr_ready_in,
	// status
	input wire busy_out,
	input wire done_out,
	input wire check_cond_out,
	input wire [3:0] sense_key_out,
	input wire [7:0] asc_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ----------------
	// checks
	// ----------------
	done_pulse_a: assert property (done_out |=> !done_out)
		else $error("done pulse too long");
	done_busy_a: assert property (done_out |-> !busy_out && $past(busy_out))
		else $error("done outside a command");
	start_busy_a: assert property (start_in && !busy_out |=> busy_out)
		else $error("start not taken");
	idle_quiet_a: assert property (!busy_out |-> !param_ready_out)
		else $error("bytes taken while idle");
	sense_set_a: assert property (check_cond_out |-> sense_key_out == SENSE_ILLEGAL_REQUEST
		&& asc_out == ASC_INVALID_PARAM_FIELD) else $error("wrong sense");
	sense_clear_a: assert property (!check_cond_out |-> sense_key_out == 4'h0 && asc_out == 8'h00)
		else $error("sense without check");
	check_when_a: assert property ($changed(check_cond_out) |-> done_out
		|| $past(start_in && !busy_out)) else $error("check moved out of turn");
	no_rej_fill_a: assert property (check_cond_out |-> !wr_valid_out)
		else $error("bytes written on a refused command");
	wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out
		&& $stable(wr_data_out) && $stable(wr_last_out)) else $error("stalled byte lost");
	// main scenarios
	cover property (done_out && check_cond_out);
	cover property (done_out && !check_cond_out);
	cover property (wr_valid_out && !wr_ready_in);
endmodule // fip_filler_props
`default_nettype wire

// *** tb/fip_init_model.sv ***
// initiator model presenting parameter list bytes
`timescale 1ns/10ps
`default_nettype none
module fip_init_model (
	// clock and control
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic slow_in,
	// byte stream
	output logic [7:0] data_out,
	output logic valid_out,
	input wire logic ready_in
);
	logic [7:0] mem [0:63];
	logic [7:0] last_q = 8'h00;
	logic gap_q = 1'b0, tick_q = 1'b0;
	int n_skip = 0, n_tot = 0, idx = 0;
	// one idle cycle after the defect bytes, while the filler still counts
	assign valid_out = idx < n_tot && !(idx == n_skip && !gap_q) && !(slow_in && tick_q);
	// released line shows the inverse of the last byte
	assign data_out = valid_out ? mem[idx[5:0]] : ~last_q;
	always @(posedge clk_in) begin
		tick_q <= !tick_q;
		if (go_in) begin
			idx <= 0;
			gap_q <= 1'b0;
		end else if (valid_out && ready_in) begin
			idx <= idx + 1;
			last_q <= data_out;
		end else if (idx == n_skip) begin
			gap_q <= 1'b1;
		end
	end
endmodule // fip_init_model
`default_nettype wire

// *** tb/fip_filler_bench.sv ***
// self-checking bench for the pattern filler
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %0h got %0h", n, e, a); end end
module fip_filler_bench;
	logic clk_in, rst_in = 1'b1, start = 1'b0, flag = 1'b0, slow = 1'b0, stall = 1'b0;
	logic [15:0] dlen = 16'h0000, bs = 16'h0001, ps = 16'h0001;
	logic [31:0] cnt = 32'h00000000, cyc = 32'h00000000;
	logic [7:0] got[$];
	logic lst[$];
	wire [7:0] pdat, wdat, asc;
	wire [3:0] sense;
	wire pval, prdy, wval, wlast, busy, done, check, wrdy;
	int error_cnt = 0, n_tests = 0;
	// sink stalls half of each eight cycles so the fifo fills
	assign wrdy = !(stall && cyc[2]);
	fip_filler i_dut (.clk_in(clk_in), .rst_in(rst_in), .start_in(start),
		.pattern_present_flag_in(flag), .defect_len_in(dlen), .block_size_in(bs),
		.phys_size_in(ps), .block_count_in(cnt), .param_data_in(pdat), .param_valid_in(pval),
		.param_ready_out(prdy), .wr_data_out(wdat), .wr_last_out(wlast), .wr_valid_out(wval),
		.wr_ready_in(wrdy), .busy_out(busy), .done_out(done), .check_cond_out(check),
		.sense_key_out(sense), .asc_out(asc));
	fip_init_model i_ini (.clk_in(clk_in), .go_in(start && !busy), .slow_in(slow),
		.data_out(pdat), .valid_out(pval), .ready_in(prdy));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc <= cyc + 32'h1;
		if (wval && wrdy) begin
			got.push_back(wdat);
			lst.push_back(wlast);
		end
	end
	task automatic cmd(input logic f, input int dl, b, p, c, input logic [1:0] s,
		input logic [7:0] t, input int n);
		int k;
		got = {};
		lst = {};
		for (k = 0; k < dl; k++)
			i_ini.mem[k] = 8'hE0 + 8'(k);
		i_ini.mem[dl] = {s, 6'h00};
		i_ini.mem[dl + 1] = t;
		i_ini.mem[dl + 2] = 8'(n >> 8);
		i_ini.mem[dl + 3] = 8'(n);
		for (k = 0; k < n; k++)
			i_ini.mem[dl + 4 + k] = 8'hA0 + 8'(k);
		i_ini.n_skip = dl;
		i_ini.n_tot = f ? dl + 4 + n : dl;
		{flag, dlen, bs, ps, cnt, start} = {f, 16'(dl), 16'(b), 16'(p), 32'(c), 1'b1};
		@(posedge clk_in);
		#1 start = 1'b0;
		k = 0;
		while ((busy !== 1'b0 || wval !== 1'b0) && k < 3000) begin
			@(posedge clk_in);
			#1 k++;
		end
	endtask
	task automatic chk_fill(input int b, p, c, input logic [1:0] s, input logic [7:0] t,
		input int n);
		int k, j, q, a;
		logic [7:0] e;
		`CHK("byte count", b * c, got.size())
		for (k = 0; k < got.size(); k++) begin
			j = k % b;
			q = k % p;
			e = (t == 8'h01) ? 8'hA0 + 8'(j % n) : 8'h00;
			a = (s == 2'h2) ? (k - q) / b : k / b;
			if ((s == 2'h1 && j < 4) || (s == 2'h2 && q < 4))
				e = 8'(a >> (8 * (3 - ((s == 2'h1) ? j : q))));
			`CHK("fill byte", e, got[k])
			`CHK("last flag", j == b - 1, lst[k])
		end
		`CHK("check flag", 1'b0, check)
	endtask
	task automatic s_plain();
		slow = 1'b1;
		cmd(1'b1, 4, 8, 8, 2, 2'h0, 8'h01, 3);
		chk_fill(8, 8, 2, 2'h0, 8'h01, 3);
		slow = 1'b0;
	endtask
	task automatic s_lba();
		stall = 1'b1;
		cmd(1'b1, 0, 6, 6, 3, 2'h1, 8'h01, 6);
		chk_fill(6, 6, 3, 2'h1, 8'h01, 6);
		stall = 1'b0;
	endtask
	task automatic s_phys();
		cmd(1'b1, 8, 6, 4, 3, 2'h2, 8'h00, 0);
		chk_fill(6, 4, 3, 2'h2, 8'h00, 0);
	endtask
	task automatic s_noflag();
		cmd(1'b0, 4, 5, 5, 2, 2'h1, 8'h01, 2);
		chk_fill(5, 5, 2, 2'h0, 8'h00, 0);
	endtask
	task automatic s_reject();
		logic [1:0] rs [8] = '{2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
		logic [7:0] rt [8] = '{8'h00, 8'h02, 8'h7F, 8'h80, 8'hFF, 8'h00, 8'h01, 8'h01};
		int rn [8] = '{0, 0, 0, 0, 0, 1, 0, 9};
		for (int i = 0; i < 8; i++) begin
			cmd(1'b1, 0, 8, 8, 2, rs[i], rt[i], rn[i]);
			`CHK("check flag", 1'b1, check)
			`CHK("sense key", 4'h5, sense)
			`CHK("sense code", 8'h26, asc)
			`CHK("bytes written", 0, got.size())
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// about a dozen commands of at most a few dozen cycles each
	initial begin
		#300000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge clk_in);
		#1 rst_in = 1'b0;
		s_plain();
		s_lba();
		s_phys();
		s_reject();
		s_noflag();
		wrap_up();
	end
endmodule // fip_filler_bench
bind fip_filler fip_filler_props #(.SENSE_ILLEGAL_REQUEST(SENSE_ILLEGAL_REQUEST),
	.ASC_INVALID_PARAM_FIELD(ASC_INVALID_PARAM_FIELD)) i_props (.*);
`default_nettype wire
